// file: scgc_top.sv
/*
 * Sleep clock gate controller: awake and sleep endpoint masks, the sleep
 * state machine, the clock request handshake and one gate per endpoint.
 * Assumes processors, DMA and endpoints all run on clk_sys, so their status
 * lines need no synchroniser, and that software reaches it over AXI4-Lite.
 */
`timescale 1ns/100ps

// Notes on behaviour
// - Every endpoint has its own enable, changeable by software at any time.
// - Gates switch without glitches, runt pulses or shortened clock periods.
// - Gating a peripheral off and on again keeps its state; no reset needed.
// - Two masks, awake and sleep, same layout, one flag per endpoint.
// - Outside sleep each gate follows its awake-mask flag.
// - Sleep only when both processors sleep and no DMA channel is busy.
// - Any processor wake interrupt leaves sleep; gates return to the awake mask.
// - In sleep each gate follows its sleep-mask flag.
// - Processor clocks are not among the masked endpoints.
// - On wake a clock handshake holds processors off the bus until clocks run.
// - The sleep mask may gate off everything, bus fabric included.
// - An endpoint may be on in sleep while off when awake.
module scgc_top
	import scgc_pkg::*;
#(
	parameter int NUM_EP = 64,
	parameter int NUM_DMA_CH = 12
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [SCGC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [SCGC_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [SCGC_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [SCGC_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] proc_asleep,
	input wire logic [1:0] proc_irq_wake,
	input wire logic [NUM_DMA_CH-1:0] dma_ch_busy,
	input wire logic [1:0] proc_clk_req,
	output logic [1:0] proc_clk_ack,
	output logic sleep_active,
	output logic [NUM_EP-1:0] clk_ep_gated
);

	// Endpoints beyond NUM_EP do not exist; their flags read as zero
	localparam logic [SCGC_MASK_W-1:0] EP_VALID =
		(NUM_EP >= SCGC_MASK_W) ? {SCGC_MASK_W{1'b1}} :
		((64'h1 << NUM_EP) - 64'h1);

	scgc_state_t state_q;
	scgc_state_t state_d;
	logic [1:0] settle_q;
	logic [SCGC_MASK_W-1:0] awake_gate_mask_q;
	logic [SCGC_MASK_W-1:0] sleep_gate_mask_q;
	logic allow_sleep_q;
	logic [SCGC_CNT_W-1:0] sleep_cnt_q;
	logic clocks_ready_q;
	logic [SCGC_MASK_W-1:0] eff_en;

	logic wr_req;
	logic [SCGC_ADDR_W-1:0] wr_addr;
	logic [SCGC_DATA_W-1:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic [SCGC_ADDR_W-1:0] rd_addr;
	logic [SCGC_DATA_W-1:0] rd_data;
	logic rd_err;

	logic enter_sleep;
	logic any_wake;
	logic dma_idle;
	logic [SCGC_DATA_W-1:0] status_word;

	// Byte-lane merge of a write into an existing word
	function automatic logic [31:0] scgc_merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_w[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Register port
	scgc_axil_slave u_axil (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_req(wr_req),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// Protection bits carry no meaning here; every access is treated alike
	logic prot_unused;
	assign prot_unused = ^{s_axi_awprot, s_axi_arprot};

	// Sleep conditions, wake has priority so a wake in the entry cycle is not lost
	assign dma_idle = ~|dma_ch_busy;
	assign any_wake = |proc_irq_wake;
	assign enter_sleep = allow_sleep_q && (&proc_asleep) && dma_idle && !any_wake;

	// Next state of the sleep machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			SCGC_ST_AWAKE: begin
				if (enter_sleep) begin
					state_d = SCGC_ST_SLEEP;
				end
			end
			SCGC_ST_SLEEP: begin
				if (any_wake) begin
					state_d = SCGC_ST_WAKE;
				end
			end
			SCGC_ST_WAKE: begin
				if (settle_q == 2'h0) begin
					state_d = SCGC_ST_AWAKE;
				end
			end
			default: begin
				state_d = SCGC_ST_AWAKE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= SCGC_ST_AWAKE;
		end else begin
			state_q <= state_d;
		end
	end

	// Wake settle counter: gates need two edges to take the awake mask
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			settle_q <= 2'h0;
		end else if (state_q == SCGC_ST_SLEEP && any_wake) begin
			settle_q <= SCGC_WAKE_SETTLE_CYC - 2'h1;
		end else if (state_q == SCGC_ST_WAKE && settle_q != 2'h0) begin
			settle_q <= settle_q - 2'h1;
		end
	end

	// Clocks-ready flag drives the handshake; it drops as sleep is entered
	// and rises only once the awake mask has reached every gate
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			clocks_ready_q <= 1'b1;
		end else begin
			clocks_ready_q <= (state_d == SCGC_ST_AWAKE);
		end
	end

	// A processor is granted the bus only while its clocks are known to run
	assign proc_clk_ack = proc_clk_req & {2{clocks_ready_q}};
	assign sleep_active = (state_q == SCGC_ST_SLEEP);

	// Mask choice; the wake state already uses the awake mask.
	// No flag is forced on, so sleep may stop the fabric too, and
	// sleep-only enables are honoured as written.
	always_comb begin
		if (state_q == SCGC_ST_SLEEP) begin
			eff_en = sleep_gate_mask_q;
		end else begin
			eff_en = awake_gate_mask_q;
		end
	end

	// One gate per endpoint; processor clocks are not in this vector and are
	// left to the cores' own sleep gating
	for (genvar i = 0; i < NUM_EP; i++) begin : g_gate
		scgc_clk_gate u_gate (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.gate_en(eff_en[i]),
			.clk_gated(clk_ep_gated[i])
		);
	end

	// Awake mask words, writable at any time, also during sleep
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			awake_gate_mask_q <= SCGC_AWAKE_RST & EP_VALID;
		end else if (wr_req) begin
			if (wr_addr == SCGC_OFS_AWAKE0) begin
				awake_gate_mask_q[31:0] <= scgc_merge(awake_gate_mask_q[31:0], wr_data,
					wr_strb) & EP_VALID[31:0];
			end else if (wr_addr == SCGC_OFS_AWAKE1) begin
				awake_gate_mask_q[63:32] <= scgc_merge(awake_gate_mask_q[63:32], wr_data,
					wr_strb) & EP_VALID[63:32];
			end
		end
	end

	// Sleep mask words, same layout as the awake mask
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sleep_gate_mask_q <= SCGC_SLEEP_RST & EP_VALID;
		end else if (wr_req) begin
			if (wr_addr == SCGC_OFS_SLEEP0) begin
				sleep_gate_mask_q[31:0] <= scgc_merge(sleep_gate_mask_q[31:0], wr_data,
					wr_strb) & EP_VALID[31:0];
			end else if (wr_addr == SCGC_OFS_SLEEP1) begin
				sleep_gate_mask_q[63:32] <= scgc_merge(sleep_gate_mask_q[63:32], wr_data,
					wr_strb) & EP_VALID[63:32];
			end
		end
	end

	// Control: software may forbid automatic sleep entry altogether
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			allow_sleep_q <= SCGC_CTRL_ALLOW_RST;
		end else if (wr_req && wr_addr == SCGC_OFS_CTRL && wr_strb[0]) begin
			allow_sleep_q <= wr_data[SCGC_CTRL_ALLOW_BIT];
		end
	end

	// Sleep entry counter, saturating; a write to its own word clears it, but an entry
	// in the same cycle wins and leaves a count of one
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sleep_cnt_q <= '0;
		end else if (state_q == SCGC_ST_AWAKE && enter_sleep) begin
			if (wr_req && wr_addr == SCGC_OFS_SLEEPCNT) begin
				sleep_cnt_q <= 16'h0001;
			end else if (sleep_cnt_q != 16'hffff) begin
				sleep_cnt_q <= sleep_cnt_q + 16'h0001;
			end
		end else if (wr_req && wr_addr == SCGC_OFS_SLEEPCNT) begin
			sleep_cnt_q <= '0;
		end
	end

	// Write decode: only unmapped words answer with an error
	always_comb begin
		if (wr_addr == SCGC_OFS_AWAKE0 || wr_addr == SCGC_OFS_AWAKE1) begin
			wr_err = 1'b0;
		end else if (wr_addr == SCGC_OFS_SLEEP0 || wr_addr == SCGC_OFS_SLEEP1) begin
			wr_err = 1'b0;
		end else if (wr_addr == SCGC_OFS_CTRL || wr_addr == SCGC_OFS_SLEEPCNT) begin
			wr_err = 1'b0;
		end else if (wr_addr == SCGC_OFS_STATUS) begin
			wr_err = 1'b0;
		end else if (wr_addr == SCGC_OFS_ACTIVE0 || wr_addr == SCGC_OFS_ACTIVE1) begin
			wr_err = 1'b0;
		end else begin
			wr_err = 1'b1;
		end
	end

	// Status word shows the machine and its inputs as the logic sees them
	always_comb begin
		status_word = '0;
		status_word[SCGC_STAT_ASLEEP_BIT] = (state_q == SCGC_ST_SLEEP);
		status_word[SCGC_STAT_WAKING_BIT] = (state_q == SCGC_ST_WAKE);
		status_word[SCGC_STAT_PSLEEP_LSB +: 2] = proc_asleep;
		status_word[SCGC_STAT_DMAIDLE_BIT] = dma_idle;
		status_word[SCGC_STAT_READY_BIT] = clocks_ready_q;
	end

	// Read decode
	always_comb begin
		rd_data = '0;
		rd_err = 1'b0;
		if (rd_addr == SCGC_OFS_AWAKE0) begin
			rd_data = awake_gate_mask_q[31:0];
		end else if (rd_addr == SCGC_OFS_AWAKE1) begin
			rd_data = awake_gate_mask_q[63:32];
		end else if (rd_addr == SCGC_OFS_SLEEP0) begin
			rd_data = sleep_gate_mask_q[31:0];
		end else if (rd_addr == SCGC_OFS_SLEEP1) begin
			rd_data = sleep_gate_mask_q[63:32];
		end else if (rd_addr == SCGC_OFS_CTRL) begin
			rd_data[SCGC_CTRL_ALLOW_BIT] = allow_sleep_q;
		end else if (rd_addr == SCGC_OFS_STATUS) begin
			rd_data = status_word;
		end else if (rd_addr == SCGC_OFS_ACTIVE0) begin
			rd_data = eff_en[31:0];
		end else if (rd_addr == SCGC_OFS_ACTIVE1) begin
			rd_data = eff_en[63:32];
		end else if (rd_addr == SCGC_OFS_SLEEPCNT) begin
			rd_data[SCGC_CNT_W-1:0] = sleep_cnt_q;
		end else begin
			rd_err = 1'b1;
		end
	end

endmodule

// file: scgc_pkg.sv
/*
 * Constants, register map and state type of the sleep clock gate controller.
 * Assumes a 32-bit AXI4-Lite register port with 8-bit byte addresses.
 */
package scgc_pkg;

	// Register port geometry
	localparam int SCGC_ADDR_W = 8;
	localparam int SCGC_DATA_W = 32;
	localparam int SCGC_MASK_W = 64;
	localparam int SCGC_CNT_W = 16;

	// Register byte offsets
	localparam logic [7:0] SCGC_OFS_AWAKE0 = 8'h00;
	localparam logic [7:0] SCGC_OFS_AWAKE1 = 8'h04;
	localparam logic [7:0] SCGC_OFS_SLEEP0 = 8'h08;
	localparam logic [7:0] SCGC_OFS_SLEEP1 = 8'h0c;
	localparam logic [7:0] SCGC_OFS_CTRL = 8'h10;
	localparam logic [7:0] SCGC_OFS_STATUS = 8'h14;
	localparam logic [7:0] SCGC_OFS_ACTIVE0 = 8'h18;
	localparam logic [7:0] SCGC_OFS_ACTIVE1 = 8'h1c;
	localparam logic [7:0] SCGC_OFS_SLEEPCNT = 8'h20;

	// Reset values
	localparam logic [63:0] SCGC_AWAKE_RST = 64'hffff_ffff_ffff_ffff;
	localparam logic [63:0] SCGC_SLEEP_RST = 64'hffff_ffff_ffff_ffff;
	localparam logic SCGC_CTRL_ALLOW_RST = 1'h1;
	localparam logic SCGC_GATE_RST = 1'h1;

	// Field positions
	localparam int SCGC_CTRL_ALLOW_BIT = 0;
	localparam int SCGC_STAT_ASLEEP_BIT = 0;
	localparam int SCGC_STAT_WAKING_BIT = 1;
	localparam int SCGC_STAT_PSLEEP_LSB = 4;
	localparam int SCGC_STAT_DMAIDLE_BIT = 8;
	localparam int SCGC_STAT_READY_BIT = 12;

	// Cycles from leaving sleep until every gate runs on the awake mask:
	// one for the enable flop in the gate cell, one for its latch phase.
	localparam logic [1:0] SCGC_WAKE_SETTLE_CYC = 2'h2;

	// AXI responses
	localparam logic [1:0] SCGC_RESP_OKAY = 2'h0;
	localparam logic [1:0] SCGC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SCGC_ST_AWAKE,
		SCGC_ST_SLEEP,
		SCGC_ST_WAKE
	} scgc_state_t;

endpackage

// file: scgc_clk_gate.sv
/*
 * One glitch-free endpoint clock gate: registered enable and a latch that is
 * transparent only while the clock is low.
 * Assumes every endpoint clock is clk_sys; the gate itself holds no user state.
 */
`timescale 1ns/100ps

module scgc_clk_gate
	import scgc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic gate_en,
	output logic clk_gated
);

	logic en_q;
	logic en_lat;

	// Enable is taken into the endpoint clock domain before the latch
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			en_q <= SCGC_GATE_RST;
		end else begin
			en_q <= gate_en;
		end
	end

	// Latch follows only in the low phase, so a change never cuts a high pulse
	always_latch begin
		if (!clk_sys) begin
			en_lat = en_q;
		end
	end

	// Stopping the clock leaves the endpoint's flops untouched; no reset here
	assign clk_gated = clk_sys & en_lat;

endmodule

// file: scgc_axil_slave.sv
/*
 * Minimal AXI4-Lite slave: takes address and data in either order, issues a
 * one-cycle write strobe, and registers read data from a combinational decode.
 * Assumes the register file answers wr_err and rd_data/rd_err in the same cycle.
 */
`timescale 1ns/100ps

module scgc_axil_slave
	import scgc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [SCGC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [SCGC_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [SCGC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [SCGC_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_req,
	output logic [SCGC_ADDR_W-1:0] wr_addr,
	output logic [SCGC_DATA_W-1:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic [SCGC_ADDR_W-1:0] rd_addr,
	input wire logic [SCGC_DATA_W-1:0] rd_data,
	input wire logic rd_err
);

	logic aw_have_q;
	logic w_have_q;

	// Each half is refused only while held or while a response waits
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready = !w_have_q && !s_axi_bvalid;
	assign wr_req = aw_have_q && w_have_q && !s_axi_bvalid;

	// Write address and data capture
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end else if (wr_req) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end else if (wr_req) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// Write response, held until the master takes it
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= SCGC_RESP_OKAY;
		end else if (wr_req) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_err ? SCGC_RESP_SLVERR : SCGC_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read: one outstanding, data registered at the address handshake
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_addr = s_axi_araddr;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= SCGC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_err ? SCGC_RESP_SLVERR : SCGC_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// file: scgc_chk.sv
/* Port checker of the sleep clock gate controller.
   Assumes it is bound to scgc_top and that everything runs on clk_sys. */
`timescale 1ns/100ps

module scgc_chk
	import scgc_pkg::*;
#(
	parameter int NUM_EP = 64,
	parameter int NUM_DMA_CH = 12
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [1:0] proc_asleep,
	input wire logic [1:0] proc_irq_wake,
	input wire logic [NUM_DMA_CH-1:0] dma_ch_busy,
	input wire logic [1:0] proc_clk_req,
	input wire logic [1:0] proc_clk_ack,
	input wire logic sleep_active,
	input wire logic [NUM_EP-1:0] clk_ep_gated
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Entry needs both cores asleep, every channel idle and no wake pending
	property p_enter;
		$rose(sleep_active) |-> $past(&proc_asleep && !(|dma_ch_busy) && !(|proc_irq_wake));
	endproperty
	a_enter: assert property (p_enter) else $error("sleep entered without cause");
	property p_exit;
		sleep_active && (|proc_irq_wake) |=> !sleep_active;
	endproperty
	a_exit: assert property (p_exit) else $error("wake did not end sleep");
	property p_stay;
		sleep_active && !(|proc_irq_wake) |=> sleep_active;
	endproperty
	a_stay: assert property (p_stay) else $error("sleep left without wake");
	property p_ack_sleep;
		sleep_active |-> proc_clk_ack == 2'h0;
	endproperty
	a_ack_sleep: assert property (p_ack_sleep) else $error("bus granted in sleep");
	// Grant comes back only after the awake mask has settled
	property p_ack_wake;
		$fell(sleep_active) |-> proc_clk_ack == 2'h0 ##1 proc_clk_ack == 2'h0
			##1 proc_clk_ack == proc_clk_req;
	endproperty
	a_ack_wake: assert property (p_ack_wake) else $error("bus grant timing on wake");
	property p_no_reenter;
		$fell(sleep_active) |-> !sleep_active [*3];
	endproperty
	a_no_reenter: assert property (p_no_reenter) else $error("sleep re-entered early");
	// Sampled just before the rising edge the gated clocks must be low: no runt pulse
	property p_gate_low;
		clk_ep_gated == '0;
	endproperty
	a_gate_low: assert property (p_gate_low) else $error("gated clock high in low phase");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
endmodule

bind scgc_top scgc_chk #(.NUM_EP(NUM_EP), .NUM_DMA_CH(NUM_DMA_CH)) u_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .proc_asleep(proc_asleep), .proc_irq_wake(proc_irq_wake),
	.dma_ch_busy(dma_ch_busy), .proc_clk_req(proc_clk_req), .proc_clk_ack(proc_clk_ack),
	.sleep_active(sleep_active), .clk_ep_gated(clk_ep_gated)
);

// file: scgc_cpu_dma_model.sv
/* Model of the two processor cores and the DMA engine.
   Assumes the bench orders sleep and wake by one-cycle command pulses. */
`timescale 1ns/100ps

module scgc_cpu_dma_model
	import scgc_pkg::*;
#(
	parameter int NUM_DMA_CH = 12
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [1:0] cmd_sleep,
	input wire logic [1:0] cmd_wake,
	input wire logic [NUM_DMA_CH-1:0] cmd_dma,
	input wire logic [1:0] proc_clk_ack,
	output logic [1:0] proc_asleep,
	output logic [1:0] proc_irq_wake,
	output logic [1:0] proc_clk_req,
	output logic [NUM_DMA_CH-1:0] dma_ch_busy,
	output int n_access
);
	// Channel activity as the bench orders it
	always_ff @(posedge clk_sys) begin
		dma_ch_busy <= rst_n ? cmd_dma : '0;
	end

	// Each core halts and gates itself; a woken core must wait for the grant
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			proc_asleep <= '0;
			proc_irq_wake <= '0;
			proc_clk_req <= '0;
			n_access <= 0;
		end else begin
			proc_irq_wake <= cmd_wake & proc_asleep;
			for (int i = 0; i < 2; i++) begin
				if (cmd_sleep[i]) begin
					proc_asleep[i] <= 1'b1;
					proc_clk_req[i] <= 1'b0;
				end else if (proc_irq_wake[i]) begin
					proc_asleep[i] <= 1'b0;
					proc_clk_req[i] <= 1'b1;
				end else if (proc_clk_req[i] && proc_clk_ack[i]) begin
					// Bus access only once granted
					proc_clk_req[i] <= 1'b0;
					n_access <= n_access + 1;
				end
			end
		end
	end
endmodule

// file: sleep_clock_gate_control_bench.sv
/* Self-checking bench of the sleep clock gate controller.
   Assumes one 40 MHz clock, synchronous reset and the core/DMA model. */
`timescale 1ns/100ps

module sleep_clock_gate_control_bench
	import scgc_pkg::*;
;
	logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, sleep_active;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, proc_asleep, proc_irq_wake, proc_clk_req;
	logic [1:0] proc_clk_ack, cmd_sleep, cmd_wake;
	logic [11:0] dma_ch_busy, cmd_dma;
	logic [63:0] clk_ep_gated;
	int n_errors, tests_run, n_access;

	scgc_top #(.NUM_EP(64), .NUM_DMA_CH(12)) uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .proc_asleep(proc_asleep), .proc_irq_wake(proc_irq_wake),
		.dma_ch_busy(dma_ch_busy), .proc_clk_req(proc_clk_req), .proc_clk_ack(proc_clk_ack),
		.sleep_active(sleep_active), .clk_ep_gated(clk_ep_gated)
	);
	scgc_cpu_dma_model #(.NUM_DMA_CH(12)) u_far (
		.clk_sys(clk_sys), .rst_n(rst_n), .cmd_sleep(cmd_sleep), .cmd_wake(cmd_wake),
		.cmd_dma(cmd_dma), .proc_clk_ack(proc_clk_ack), .proc_asleep(proc_asleep),
		.proc_irq_wake(proc_irq_wake), .proc_clk_req(proc_clk_req),
		.dma_ch_busy(dma_ch_busy), .n_access(n_access)
	);

	// 25 ns period
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Handshakes are judged at the falling edge, where ready is settled until the next rise
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		int n;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(negedge clk_sys);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk_sys);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (n == 64) n_errors++;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic hs, v;
		int n;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(negedge clk_sys);
			hs = s_axi_arvalid && s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk_sys);
			if (hs) s_axi_arvalid <= 1'b0;
			if (v) begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (n == 64) n_errors++;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk($sformatf("reg %h", a), {32'h0, exp}, {32'h0, d});
	endtask

	// Sampled in the high phase, a gated clock shows its enable
	task automatic get_gates(output logic [63:0] g);
		@(posedge clk_sys);
		#5;
		g = clk_ep_gated;
	endtask

	task automatic wait_sleep(input logic exp);
		for (int n = 0; n < 50 && sleep_active !== exp; n++) @(negedge clk_sys);
		chk("sleep_active", {63'h0, exp}, {63'h0, sleep_active});
	endtask

	task automatic pulse(input logic wake, input logic [1:0] v);
		@(posedge clk_sys);
		if (wake) cmd_wake <= v;
		else cmd_sleep <= v;
		@(posedge clk_sys);
		cmd_wake <= 2'h0;
		cmd_sleep <= 2'h0;
	endtask

	task automatic t_reset_values();
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 4; i++) rd_chk(8'(4 * i), 32'hffff_ffff);
		rd_chk(SCGC_OFS_STATUS, 32'h0000_1100);
		rd_chk(SCGC_OFS_SLEEPCNT, 32'h0);
		rd(8'h24, d, r);
		chk("unmapped rresp", 64'(SCGC_RESP_SLVERR), 64'(r));
		wr(8'h24, 32'h0, r);
		chk("unmapped bresp", 64'(SCGC_RESP_SLVERR), 64'(r));
		$display("test reset_values done");
	endtask

	task automatic t_awake_mask();
		logic [63:0] g;
		logic [1:0] r;
		wr(SCGC_OFS_AWAKE1, 32'h8000_0001, r); // Fabric and stack memory kept on
		wr(SCGC_OFS_AWAKE0, 32'h0000_00a5, r);
		rd_chk(SCGC_OFS_ACTIVE0, 32'h0000_00a5);
		get_gates(g);
		chk("gates", 64'h8000_0001_0000_00a5, g);
		wr(SCGC_OFS_AWAKE0, 32'h0000_005a, r);
		get_gates(g);
		chk("gates", 64'h8000_0001_0000_005a, g);
		$display("test awake_mask done");
	endtask

	task automatic t_sleep_cycle(input logic [1:0] waker, input logic [31:0] cnt);
		logic [63:0] g;
		logic [1:0] r;
		int n0;
		wr(SCGC_OFS_SLEEP0, 32'h0000_0300, r); // On only while asleep
		wr(SCGC_OFS_SLEEP1, 32'h0, r); // Fabric off as well
		cmd_dma <= 12'h800;
		pulse(1'b0, 2'h3);
		repeat (8) @(posedge clk_sys);
		chk("sleep_active", 64'h0, {63'h0, sleep_active});
		rd_chk(SCGC_OFS_STATUS, 32'h0000_1030);
		cmd_dma <= 12'h0;
		wait_sleep(1'b1);
		chk("ack", 64'h0, {62'h0, proc_clk_ack});
		repeat (2) @(posedge clk_sys);
		get_gates(g);
		chk("gates", 64'h300, g);
		rd_chk(SCGC_OFS_STATUS, 32'h0000_0131);
		n0 = n_access;
		pulse(1'b1, waker);
		wait_sleep(1'b0);
		@(posedge clk_sys);
		get_gates(g);
		chk("gates", 64'h8000_0001_0000_005a, g);
		repeat (4) @(posedge clk_sys);
		chk("accesses", 64'(n0 + 1), 64'(n_access));
		rd_chk(SCGC_OFS_SLEEPCNT, cnt);
		$display("test sleep_cycle done");
	endtask

	initial begin
		n_errors = 0;
		tests_run = 0;
		rst_n = 1'b0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		cmd_sleep = 2'h0;
		cmd_wake = 2'h0;
		cmd_dma = 12'h0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset_values();
		t_awake_mask();
		t_sleep_cycle(2'h1, 32'h1);
		t_sleep_cycle(2'h2, 32'h2);
		stop_test();
	end

	// Tests take under 1000 cycles; cut a hang after 4000
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
endmodule
